// ### common/uab_pkg.sv
/*
 * Package for the serial address match and baud rate block: register map,
 * field positions, reset values, timing counts and the frame carrier struct.
 * Assumes a single 200 MHz bus clock and an APB master with 32-bit data.
 */
`default_nettype none

package uab_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] AUX_CTRL_ADDR   = 12'h08e << 2;
	localparam logic [11:0] BAUD_RELOAD_ADDR = 12'h09c << 2;
	localparam logic [11:0] SLAVE_ADDR_ADDR = 12'h400;
	localparam logic [11:0] SLAVE_MASK_ADDR = 12'h404;
	localparam logic [11:0] UART_CTRL_ADDR  = 12'h408;
	localparam logic [11:0] STATUS_ADDR     = 12'h40c;
	localparam logic [11:0] IRQ_MASK_ADDR   = 12'h410;
	localparam logic [11:0] RX_DATA_ADDR    = 12'h414;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int AUX_SRC_BIT    = 0;
	localparam int AUX_BRT_RUN    = 4;
	localparam int AUX_FAST_SHIFT = 5;
	localparam int CTL_MODE_LO    = 0;
	localparam int CTL_FILTER     = 2;
	localparam int CTL_DOUBLER    = 3;
	localparam int ST_RX_FLAG     = 0;
	localparam int ST_MATCH       = 1;
	localparam int ST_DROPPED     = 2;
	// ---------------------------------------------------------------
	// Reset values and dividers
	// ---------------------------------------------------------------
	localparam logic [7:0] AUX_RESET    = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] SLAVE_ADDRESS_REG_RESET  = 8'h00;
	localparam logic [7:0] SMASK_RESET  = 8'h00;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [6:0] DIV_SHIFT_SLOW = 7'd12;
	localparam logic [6:0] DIV_SHIFT_FAST = 7'd2;
	localparam logic [6:0] DIV_M2_SLOW    = 7'd64;
	localparam logic [6:0] DIV_M2_FAST    = 7'd32;
	localparam logic [5:0] OVF_PER_BIT    = 6'd32;

	typedef enum logic [1:0] {
		UAB_MODE_SHIFT,
		UAB_MODE_8BIT,
		UAB_MODE_9BIT_FIXED,
		UAB_MODE_9BIT_VAR
	} uab_mode_t;

	// Completed frame from the receive shifter
	typedef struct packed {
		logic       done;
		logic [7:0] data;
		logic       ninth;
		logic       stop_ok;
	} uab_frame_t;
endpackage : uab_pkg

`default_nettype wire

// ### core/uab_core.sv
/*
 * Address recognition and baud rate selection for a serial port, with an
 * APB register slave and a level interrupt.
 * Assumes the frame shifter delivers one-cycle frame pulses and that the
 * timer 1 overflow arrives as a one-cycle pulse on pclk.
 */
// Implementation choice: the APB slave port.
`default_nettype none

module uab_core (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              timer1_ovf,
	input  wire uab_pkg::uab_frame_t frame_in,
	output logic                   bit_tick,
	output logic                   receive_flag,
	output logic                   irq
);
	logic [7:0] aux_reg;
	logic [7:0] reload_reg;
	logic [7:0] slave_address_reg;
	logic [7:0] slave_address_mask;
	logic [7:0] ctrl_reg;
	logic [2:0] status_reg;
	logic [2:0] irq_mask_reg;
	logic [7:0] rx_data_reg;
	logic [7:0] brt_cnt_reg;
	logic       brt_ovf;
	logic [5:0] div_cnt_reg;
	logic [4:0] ovf_cnt_reg;
	logic       ovf_sel;
	logic       baud_doubler;
	logic       address_filter_enable;
	logic       fast_shift_mode;
	logic       baud_source_select;
	uab_pkg::uab_mode_t mode;
	logic       wr_en;
	logic       rd_en;
	logic       hit;
	logic       accept;
	logic [2:0] events;
	logic [6:0] since_tick_reg;
	logic       cfg_clean_reg;

	assign mode                  = uab_pkg::uab_mode_t'(ctrl_reg[uab_pkg::CTL_MODE_LO +: 2]);
	assign address_filter_enable = ctrl_reg[uab_pkg::CTL_FILTER];
	assign baud_doubler          = ctrl_reg[uab_pkg::CTL_DOUBLER];
	assign fast_shift_mode       = aux_reg[uab_pkg::AUX_FAST_SHIFT];
	assign baud_source_select    = aux_reg[uab_pkg::AUX_SRC_BIT];

	// ---------------------------------------------------------------
	// Address recognition
	// ---------------------------------------------------------------
	function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] sa,
		input logic [7:0] sm);
		logic given;
		logic bcast;
		given = ((rx ^ (sa & sm)) & sm) == 8'h00;
		bcast = ((rx ^ (sa | sm)) & (sa | sm)) == 8'h00;
		return given | bcast;
	endfunction : addr_match

	assign hit = addr_match(frame_in.data, slave_address_reg, slave_address_mask);

	always_comb begin
		accept = 1'b1;
		if (address_filter_enable) begin
			case (mode)
				uab_pkg::UAB_MODE_8BIT:  accept = frame_in.stop_ok & hit;
				uab_pkg::UAB_MODE_9BIT_FIXED,
				uab_pkg::UAB_MODE_9BIT_VAR: accept = frame_in.ninth & hit;
				default: accept = 1'b1;
			endcase
		end
	end

	assign events = {frame_in.done & ~accept, frame_in.done & accept & hit,
		frame_in.done & accept};

	// ---------------------------------------------------------------
	// Baud generation
	// ---------------------------------------------------------------
	// Dedicated 8-bit reload timer, one count per clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brt_cnt_reg <= 8'h00;
		end else if (!aux_reg[uab_pkg::AUX_BRT_RUN]) begin
			brt_cnt_reg <= reload_reg;
		end else if (brt_cnt_reg == 8'hff) begin
			brt_cnt_reg <= reload_reg;
		end else begin
			brt_cnt_reg <= brt_cnt_reg + 8'h01;
		end
	end
	assign brt_ovf = aux_reg[uab_pkg::AUX_BRT_RUN] && brt_cnt_reg == 8'hff;

	// Source bit clear: any timer 1 overflow counts, whatever mode made it; set: the reload timer overflow
	assign ovf_sel = baud_source_select ? brt_ovf : timer1_ovf;

	// Last count of the fixed divider; divisor 64 needs seven bits
	function automatic logic [5:0] fixed_last(input uab_pkg::uab_mode_t m, input logic fs,
		input logic dbl);
		logic [6:0] dv;
		if (m == uab_pkg::UAB_MODE_SHIFT) begin
			dv = fs ? uab_pkg::DIV_SHIFT_FAST : uab_pkg::DIV_SHIFT_SLOW;
		end else begin
			dv = dbl ? uab_pkg::DIV_M2_FAST : uab_pkg::DIV_M2_SLOW;
		end
		dv = dv - 7'd1;
		return dv[5:0];
	endfunction : fixed_last

	// Last overflow count of a bit; the doubler halves the count
	function automatic logic [4:0] ovf_last(input logic dbl);
		logic [5:0] n;
		n = (uab_pkg::OVF_PER_BIT >> dbl) - 6'd1;
		return n[4:0];
	endfunction : ovf_last

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 6'd0;
		end else if (div_cnt_reg >= fixed_last(mode, fast_shift_mode, baud_doubler)) begin
			div_cnt_reg <= 6'd0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 6'd1;
		end
	end

	// Doubler halves the overflow count per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_cnt_reg <= 5'd0;
		end else if (ovf_sel) begin
			if (ovf_cnt_reg >= ovf_last(baud_doubler)) begin
				ovf_cnt_reg <= 5'd0;
			end else begin
				ovf_cnt_reg <= ovf_cnt_reg + 5'd1;
			end
		end
	end

	always_comb begin
		if (mode == uab_pkg::UAB_MODE_8BIT || mode == uab_pkg::UAB_MODE_9BIT_VAR) begin
			bit_tick = ovf_sel && ovf_cnt_reg == ovf_last(baud_doubler);
		end else begin
			bit_tick = div_cnt_reg == fixed_last(mode, fast_shift_mode, baud_doubler);
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_reg            <= uab_pkg::AUX_RESET;
			reload_reg         <= uab_pkg::RELOAD_RESET;
			slave_address_reg  <= uab_pkg::SLAVE_ADDRESS_REG_RESET;
			slave_address_mask <= uab_pkg::SMASK_RESET;
			ctrl_reg           <= uab_pkg::CTRL_RESET;
			irq_mask_reg       <= 3'h0;
		end else if (wr_en) begin
			if (paddr == uab_pkg::AUX_CTRL_ADDR) begin
				aux_reg <= pwdata[7:0];
			end else if (paddr == uab_pkg::BAUD_RELOAD_ADDR) begin
				reload_reg <= pwdata[7:0];
			end else if (paddr == uab_pkg::SLAVE_ADDR_ADDR) begin
				slave_address_reg <= pwdata[7:0];
			end else if (paddr == uab_pkg::SLAVE_MASK_ADDR) begin
				slave_address_mask <= pwdata[7:0];
			end else if (paddr == uab_pkg::UART_CTRL_ADDR) begin
				ctrl_reg <= {4'h0, pwdata[3:0]};
			end else if (paddr == uab_pkg::IRQ_MASK_ADDR) begin
				irq_mask_reg <= pwdata[2:0];
			end
		end
	end

	// Read clears status, but a same-cycle event still sets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 3'h0;
		end else if (rd_en && paddr == uab_pkg::STATUS_ADDR) begin
			status_reg <= events;
		end else begin
			status_reg <= status_reg | events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_reg <= 8'h00;
		end else if (events[uab_pkg::ST_RX_FLAG]) begin
			rx_data_reg <= frame_in.data;
		end
	end

	always_comb begin
		prdata = 32'h0;
		if (paddr == uab_pkg::AUX_CTRL_ADDR) begin
			prdata = {24'h0, aux_reg};
		end else if (paddr == uab_pkg::BAUD_RELOAD_ADDR) begin
			prdata = {24'h0, reload_reg};
		end else if (paddr == uab_pkg::SLAVE_ADDR_ADDR) begin
			prdata = {24'h0, slave_address_reg};
		end else if (paddr == uab_pkg::SLAVE_MASK_ADDR) begin
			prdata = {24'h0, slave_address_mask};
		end else if (paddr == uab_pkg::UART_CTRL_ADDR) begin
			prdata = {24'h0, ctrl_reg};
		end else if (paddr == uab_pkg::STATUS_ADDR) begin
			prdata = {29'h0, status_reg};
		end else if (paddr == uab_pkg::IRQ_MASK_ADDR) begin
			prdata = {29'h0, irq_mask_reg};
		end else if (paddr == uab_pkg::RX_DATA_ADDR) begin
			prdata = {24'h0, rx_data_reg};
		end
	end

	assign receive_flag = status_reg[uab_pkg::ST_RX_FLAG];
	assign irq          = |(status_reg & irq_mask_reg);

	// Cycles since the last bit tick, saturating; feeds the rate checks only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_tick_reg <= 7'd0;
		end else if (bit_tick) begin
			since_tick_reg <= 7'd0;
		end else if (since_tick_reg != 7'h7f) begin
			since_tick_reg <= since_tick_reg + 7'd1;
		end
	end

	// Any write may move the rate, so it spoils the current tick window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_clean_reg <= 1'b0;
		end else if (bit_tick) begin
			cfg_clean_reg <= ~wr_en;
		end else if (wr_en) begin
			cfg_clean_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	nine_bit_filter_a: assert property (frame_in.done && address_filter_enable
		&& mode[1] && !frame_in.ninth |=> !status_reg[0] || $past(status_reg[0]))
		else $error("nine-bit frame without ninth bit flagged");
	mode1_stop_a: assert property (frame_in.done && address_filter_enable
		&& mode == uab_pkg::UAB_MODE_8BIT && !frame_in.stop_ok |-> !events[0])
		else $error("mode 1 frame without stop flagged");
	shift_ignore_a: assert property (frame_in.done
		&& mode == uab_pkg::UAB_MODE_SHIFT |-> events[0])
		else $error("shift mode frame dropped");
	given_match_a: assert property (frame_in.done && address_filter_enable
		&& mode[1] && frame_in.ninth
		&& (frame_in.data & slave_address_mask) == (slave_address_reg & slave_address_mask)
		|=> status_reg[1])
		else $error("given address not matched");
	broadcast_a: assert property (frame_in.done && mode[1] && frame_in.ninth
		&& address_filter_enable && frame_in.data == 8'hff |=> status_reg[0])
		else $error("broadcast address not matched");
	zero_regs_a: assert property ($rose(presetn) |-> slave_address_reg == 8'h00
		&& slave_address_mask == 8'h00 && !baud_doubler)
		else $error("address registers not cleared");
	shift_rate_a: assert property (mode == uab_pkg::UAB_MODE_SHIFT && !fast_shift_mode
		&& bit_tick && cfg_clean_reg |-> since_tick_reg == uab_pkg::DIV_SHIFT_SLOW - 7'd1)
		else $error("shift rate wrong");
	mode2_rate_a: assert property (mode == uab_pkg::UAB_MODE_9BIT_FIXED && bit_tick
		&& cfg_clean_reg |-> since_tick_reg
		== (baud_doubler ? uab_pkg::DIV_M2_FAST : uab_pkg::DIV_M2_SLOW) - 7'd1)
		else $error("mode 2 rate wrong");
	ovf_rate_a: assert property (ovf_sel && mode == uab_pkg::UAB_MODE_8BIT
		&& baud_doubler && ovf_cnt_reg == 5'd15 |-> bit_tick)
		else $error("doubled overflow tick missing");
	match_rule_a: assert property (frame_in.done && (frame_in.data & slave_address_mask)
		== (slave_address_reg & slave_address_mask) |-> hit)
		else $error("masked compare wrong");

	filtered_hit_c: cover property (frame_in.done && address_filter_enable && events[1]);
	filtered_drop_c: cover property (frame_in.done && events[2]);
	brt_tick_c: cover property (baud_source_select && bit_tick);
endmodule : uab_core

`default_nettype wire

// ### bench/uab_partner.sv
/*
 * Far-side model: serial frame source and timer 1 overflow source.
 * Assumes the bench calls send_frame and sets ovf_period hierarchically.
 */
`default_nettype none

module uab_partner (
	input  wire logic          pclk,
	input  wire logic          presetn,
	output var  logic          timer1_ovf,
	output var  uab_pkg::uab_frame_t frame_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int ovf_period = 0;
	int cnt = 0;
	initial begin
		timer1_ovf = 1'b0;
		frame_in = '0;
	end
	// Same pulse whatever the timer's counting mode; zero stops it
	always @(posedge pclk) begin
		if (presetn && ovf_period > 0 && cnt >= ovf_period - 1) begin
			cnt <= 0;
			timer1_ovf <= 1'b1;
		end else begin
			cnt <= (presetn && ovf_period > 0) ? cnt + 1 : 0;
			timer1_ovf <= 1'b0;
		end
	end
	// Fields are inverted once the frame pulse is over, never left stale
	task send_frame(input logic [7:0] d, input logic n, input logic s);
		@(posedge pclk);
		frame_in <= '{1'b1, d, n, s};
		@(posedge pclk);
		frame_in <= '{1'b0, ~d, ~n, ~s};
	endtask : send_frame
endmodule : uab_partner

`default_nettype wire

// ### bench/tb.sv
/*
 * Self-checking bench: APB register access, address filtering, interrupt
 * and bit rate checks. Assumes a zero-wait APB slave and 200 MHz pclk.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, q;
	logic        qe;
	wire  logic [31:0] prdata;
	wire  logic  pready, pslverr, bit_tick, receive_flag, irq, timer1_ovf;
	uab_pkg::uab_frame_t frame_in;
	int fail_count = 0, cmp_count = 0, i, m;
	logic [7:0] fd [7] = '{8'hc2, 8'hc0, 8'hc1, 8'hff, 8'h80, 8'hc0, 8'h00};
	logic       fn [7] = '{1, 1, 1, 1, 1, 0, 1};
	logic [7:0] bc [8] = '{8'h00, 8'h00, 8'h02, 8'h0a, 8'h01, 8'h09, 8'h03, 8'h0b};
	logic [7:0] ba [8] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h11};
	int         bg [8] = '{12, 2, 64, 32, 96, 48, 128, 64};

	always #2.5 pclk = ~pclk;

	uab_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer1_ovf(timer1_ovf),
		.frame_in(frame_in), .bit_tick(bit_tick), .receive_flag(receive_flag), .irq(irq));
	uab_partner p (.pclk(pclk), .presetn(presetn), .timer1_ovf(timer1_ovf),
		.frame_in(frame_in));

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task results;
		$display("errors %0d compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Answer is captured while it stands before the edge that ends the access
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			rdy = pready;
			q = prdata;
			qe = pslverr;
			@(posedge pclk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (rdy !== 1'b1) begin
			fail_count++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(nm, e, q);
	endtask : rdchk

	function automatic logic hit(input logic [7:0] d, input logic [7:0] sa,
			input logic [7:0] sm);
		return (((d ^ sa) & sm) == 8'h00) || ((d & (sa | sm)) == (sa | sm));
	endfunction : hit

	// Expected status is {dropped, hit, accepted}; msk hides unchecked bits
	task frm(input logic [7:0] d, input logic n, input logic s, input logic acc,
			input logic h, input logic [2:0] msk);
		p.send_frame(d, n, s);
		repeat (2) @(posedge pclk);
		apb(1'b0, uab_pkg::STATUS_ADDR, '0);
		chk("status", {29'h0, {~acc, acc & h, acc} & msk}, q & {29'h0, msk});
		if (acc)
			rdchk("rx_data", uab_pkg::RX_DATA_ADDR, {24'h0, d});
	endtask : frm

	task gap(input int e);
		int n, k;
		for (k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (bit_tick !== 1'b1 && n < 5000);
			if (bit_tick !== 1'b1) begin
				fail_count++;
				results();
			end
		end
		chk("bit_tick gap", e, n);
	endtask : gap

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("slave_addr", uab_pkg::SLAVE_ADDR_ADDR, 0);
		rdchk("slave_mask", uab_pkg::SLAVE_MASK_ADDR, 0);
		rdchk("uart_ctrl", uab_pkg::UART_CTRL_ADDR, 0);
		rdchk("aux_ctrl", uab_pkg::AUX_CTRL_ADDR, 0);
		rdchk("unmapped", 12'hffc, 0);
		chk("pslverr", 0, {31'h0, qe});
		apb(1'b1, uab_pkg::UART_CTRL_ADDR, 32'h7);
		frm(8'h5a, 1'b1, 1'b1, 1'b1, 1'b1, 3'h7);
		apb(1'b1, uab_pkg::SLAVE_ADDR_ADDR, 32'hc0);
		apb(1'b1, uab_pkg::SLAVE_MASK_ADDR, 32'hfd);
		for (m = 2; m < 4; m++) begin
			apb(1'b1, uab_pkg::UART_CTRL_ADDR, 32'h4 | m);
			for (i = 0; i < 7; i++)
				frm(fd[i], fn[i], 1'b1, fn[i] & hit(fd[i], 8'hc0, 8'hfd),
					1'b1, 3'h7);
		end
		apb(1'b1, uab_pkg::UART_CTRL_ADDR, 32'h5);
		frm(8'hc0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h7);
		frm(8'hc0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h7);
		frm(8'h80, 1'b0, 1'b1, 1'b0, 1'b0, 3'h7);
		apb(1'b1, uab_pkg::UART_CTRL_ADDR, 32'h4);
		frm(8'h80, 1'b0, 1'b0, 1'b1, 1'b0, 3'h5);
		apb(1'b1, uab_pkg::UART_CTRL_ADDR, 32'h3);
		frm(8'h80, 1'b0, 1'b1, 1'b1, 1'b0, 3'h5);
		p.send_frame(8'h11, 1'b0, 1'b1);
		@(negedge pclk);
		chk("irq masked", 0, irq);
		chk("receive_flag", 1, receive_flag);
		apb(1'b1, uab_pkg::IRQ_MASK_ADDR, 32'h1);
		@(negedge pclk);
		chk("irq", 1, irq);
		rdchk("status", uab_pkg::STATUS_ADDR, 32'h1);
		@(negedge pclk);
		chk("irq cleared", 0, irq);
		chk("receive_flag cleared", 0, receive_flag);
		rdchk("status cleared", uab_pkg::STATUS_ADDR, 0);
		apb(1'b1, uab_pkg::BAUD_RELOAD_ADDR, 32'hfc);
		p.ovf_period = 3;
		for (i = 0; i < 8; i++) begin
			apb(1'b1, uab_pkg::UART_CTRL_ADDR, {24'h0, bc[i]});
			apb(1'b1, uab_pkg::AUX_CTRL_ADDR, {24'h0, ba[i]});
			gap(bg[i]);
		end
		results();
	end
endmodule : tb

`default_nettype wire
